// ==== rtl/swp_status_write.sv ====
module swp_status_write (
    input  logic                       clk,
    input  logic                       rst_n,
    input  logic                       cs_n,
    input  logic                       sclk,
    input  logic                       si,
    output logic [swp_pkg::REG_W-1:0]  status_byte_one,
    output logic [swp_pkg::REG_W-1:0]  status_byte_two,
    output logic [swp_pkg::REG_W-1:0]  status_byte_three,
    output logic [swp_pkg::REG_W-1:0]  status_byte_four,
    output logic [swp_pkg::REG_W-1:0]  status_byte_five,
    output logic                       write_enable_latch,
    output logic                       protect_lock_bit_high,
    output logic                       protect_lock_bit_low,
    output logic                       volatile_enable,
    output logic                       regs_locked
);
    import swp_pkg::*;

    // Synchronised pins
    logic                  cs_n_s;
    logic                  sclk_s;
    logic                  si_s;

    // Byte receiver outputs
    logic                  byte_valid;
    logic [REG_W-1:0]      byte_data;
    logic [BIT_CNT_W-1:0]  bit_cnt;
    logic [BYTE_CNT_W-1:0] byte_cnt;

    // Frame capture
    logic                  cs_d_reg;
    swp_cmd_t              cmd_reg;
    swp_cmd_t              cmd_next;
    logic [REG_W-1:0]      op_reg;
    logic [REG_W-1:0]      op_next;
    logic [REG_W-1:0]      b1_reg;
    logic [REG_W-1:0]      b1_next;
    logic [REG_W-1:0]      b2_reg;
    logic [REG_W-1:0]      b2_next;

    // Status storage; write enable lives inside byte one
    logic [NUM_SR-1:0][REG_W-1:0] sr_reg;
    logic [NUM_SR-1:0][REG_W-1:0] sr_next;
    logic [NUM_SR-1:0]            sr_we;
    logic [NUM_SR-1:0][REG_W-1:0] sr_wd;
    logic                  vol_reg;
    logic                  vol_next;
    logic                  lock_reg;
    logic                  lock_next;
    logic                  latch_next;

    // Pins cross into the clk domain through two flops
    swp_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (SYNC_IDLE)
    ) u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .async_in ({cs_n, sclk, si}),
        .sync_out ({cs_n_s, sclk_s, si_s})
    );

    // Serial to byte conversion and frame position
    swp_byte_rx u_rx (
        .clk        (clk),
        .rst_n      (rst_n),
        .cs_n_s     (cs_n_s),
        .sclk_s     (sclk_s),
        .si_s       (si_s),
        .byte_valid (byte_valid),
        .byte_data  (byte_data),
        .bit_cnt    (bit_cnt),
        .byte_cnt   (byte_cnt)
    );

    // Direct opcode to target index
    function automatic logic [2:0] direct_idx(input logic [REG_W-1:0] op);
        case (op)
            OP_WR_SR2: direct_idx = 3'(IDX_SR2);
            OP_WR_SR3: direct_idx = 3'(IDX_SR3);
            default:   direct_idx = 3'(IDX_SR1);
        endcase
    endfunction

    // Frame end and its alignment
    wire frame_end = cs_n_s & ~cs_d_reg;
    wire aligned   = (bit_cnt == BIT_ZERO);
    wire end_ok    = frame_end & aligned;

    // Bytes after the opcode; a saturated count stays above two
    wire [BYTE_CNT_W-1:0] body_cnt =
        (byte_cnt == CNT_NONE) ? CNT_NONE : byte_cnt - BYTE_CNT_W'(1);

    // Current status flags
    wire latch     = sr_reg[IDX_SR1][LATCH_BIT];
    wire prot_low  = sr_reg[IDX_SR1][PROT_LOW_BIT];
    wire prot_high = sr_reg[IDX_SR2][PROT_HIGH_BIT];

    // Either enable opens a direct write, never past the lock
    wire wr_allow  = (latch | vol_reg) & ~lock_reg;

    // Direct write: one byte, or two for the legacy 01h form
    wire dir_pair  = (op_reg == OP_WR_SR1) & (body_cnt == BODY_TWO);
    wire dir_ok    = end_ok & (cmd_reg == CMD_DIRECT) & wr_allow
                   & ((body_cnt == BODY_ONE) | dir_pair);
    wire [2:0] dir_idx = direct_idx(op_reg);

    // Indirect write: exactly address plus one data byte
    wire ind_ok    = end_ok & (cmd_reg == CMD_INDIRECT) & latch & ~lock_reg
                   & (body_cnt == BODY_TWO) & addr_ok(b1_reg);
    wire [2:0] ind_idx = b1_reg[2:0] - ADDR_SR_FIRST[2:0];

    // Lock needs enable, both protect bits and both keys in order
    wire keys_ok   = (b1_reg == LOCK_KEY1) & (b2_reg == LOCK_KEY2);
    wire lock_ok   = end_ok & (cmd_reg == CMD_LOCK) & latch & (body_cnt == BODY_TWO)
                   & keys_ok & prot_high & prot_low;

    // Frames that set or consume the enables
    wire status_end = end_ok & ((cmd_reg == CMD_DIRECT) | (cmd_reg == CMD_INDIRECT));
    wire latch_clear = status_end | (end_ok & (cmd_reg == CMD_LOCK));
    wire latch_set   = end_ok & (cmd_reg == CMD_WREN) & (body_cnt == CNT_NONE);
    wire vol_set    = end_ok & (cmd_reg == CMD_VWREN) & (body_cnt == CNT_NONE);

    // Write enable: unaligned ends leave it untouched
    assign latch_next = latch_set ? 1'b1 : (latch_clear ? 1'b0 : latch);
    assign vol_next  = vol_set ? 1'b1 : (status_end ? 1'b0 : vol_reg);
    assign lock_next = lock_reg | lock_ok;                          // Only reset unlocks

    // Capture opcode, then first and second body byte
    wire cap_op = byte_valid & (byte_cnt == CNT_OPCODE);
    wire cap_b1 = byte_valid & (byte_cnt == CNT_FIRST);
    wire cap_b2 = byte_valid & (byte_cnt == CNT_SECOND);
    assign cmd_next = frame_end ? CMD_NONE : (cap_op ? cmd_of(byte_data) : cmd_reg);
    assign op_next  = cap_op ? byte_data : op_reg;
    assign b1_next  = cap_b1 ? byte_data : b1_reg;
    assign b2_next  = cap_b2 ? byte_data : b2_reg;

    // Per-register write strobe and data
    for (genvar i = 0; i < NUM_SR; i++) begin : g_sr
        wire pair_hi = dir_pair & (i == IDX_SR2);
        assign sr_we[i]   = (dir_ok & ((dir_idx == 3'(i)) | pair_hi))
                          | (ind_ok & (ind_idx == 3'(i)));
        assign sr_wd[i]   = (dir_ok & ~pair_hi) ? b1_reg : b2_reg;
        assign sr_next[i] = sr_we[i] ? sr_wd[i] : sr_reg[i];
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cs_d_reg <= 1'b1;
            cmd_reg  <= CMD_NONE;
            op_reg   <= SR_RESET;
            b1_reg   <= SR_RESET;
            b2_reg   <= SR_RESET;
        end else begin
            cs_d_reg <= cs_n_s;
            cmd_reg  <= cmd_next;
            op_reg   <= op_next;
            b1_reg   <= b1_next;
            b2_reg   <= b2_next;
        end
    end

    // Status bytes; the latch bit overrides any written value
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sr_reg   <= {NUM_SR{SR_RESET}};
            vol_reg  <= 1'b0;
            lock_reg <= 1'b0;
        end else begin
            sr_reg                   <= sr_next;
            sr_reg[IDX_SR1][LATCH_BIT] <= latch_next;
            vol_reg                  <= vol_next;
            lock_reg                 <= lock_next;
        end
    end

    // Outputs straight from the flops
    assign status_byte_one       = sr_reg[0];
    assign status_byte_two       = sr_reg[1];
    assign status_byte_three     = sr_reg[2];
    assign status_byte_four      = sr_reg[3];
    assign status_byte_five      = sr_reg[4];
    assign write_enable_latch    = latch;
    assign protect_lock_bit_high = prot_high;
    assign protect_lock_bit_low  = prot_low;
    assign volatile_enable       = vol_reg;
    assign regs_locked           = lock_reg;

    // Checks: most tie a frame end to the state one cycle later; the lock-rise, deselect and capture checks do not

    sequence s_direct_end;
        frame_end && aligned && cmd_reg == CMD_DIRECT;
    endsequence

    sequence s_ind_end;
        frame_end && aligned && cmd_reg == CMD_INDIRECT;
    endsequence

    sequence s_wren_frame;
        frame_end && aligned && cmd_reg == CMD_WREN && body_cnt == CNT_NONE;
    endsequence

    sequence s_lock_rise;
        !lock_reg ##1 lock_reg;
    endsequence

    // Register one without its latch bit, which refused frames may still clear
    wire [REG_W-1:0] latch_mask = REG_W'(1) << LATCH_BIT;
    wire [REG_W-1:0] sr1_kept   = status_byte_one & ~latch_mask;

    sequence s_vwren_frame;
        frame_end && aligned && cmd_reg == CMD_VWREN && body_cnt == CNT_NONE;
    endsequence

    // All data held: a refused write must leave every status bit but the latch bit alone
    sequence s_data_held;
        $stable(sr1_kept) && $stable(status_byte_two) && $stable(status_byte_three)
        && $stable(status_byte_four) && $stable(status_byte_five);
    endsequence

    wel_set_check_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_wren_frame |=> write_enable_latch)
        else $error("write enable not set after enable frame");

    direct_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_direct_end |=> !write_enable_latch)
        else $error("write enable still set after direct write");

    misalign_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        frame_end && !aligned |=> $stable(sr_reg) && $stable(lock_reg) && $stable(vol_reg))
        else $error("unaligned frame changed state");

    pair_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_direct_end ##0 (wr_allow && op_reg == OP_WR_SR1 && body_cnt == BODY_TWO)
        |=> status_byte_two == $past(b2_reg) && status_byte_one[PROT_LOW_BIT] ==
            $past(b1_reg[PROT_LOW_BIT]))
        else $error("two byte direct write misplaced");

    single_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_direct_end ##0 (op_reg == OP_WR_SR1 && body_cnt == BODY_ONE)
        |=> $stable(status_byte_two))
        else $error("single byte write touched register two");

    ind_excess_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_ind_end ##0 (body_cnt > BODY_TWO) |=> s_data_held)
        else $error("indirect write with extra data changed a register");

    bad_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_ind_end ##0 !addr_ok(b1_reg)
        |=> !write_enable_latch && $stable(status_byte_two) && $stable(status_byte_five))
        else $error("bad indirect address not aborted");

    ind_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_ind_end ##0 (latch && !lock_reg && body_cnt == BODY_TWO && b1_reg == ADDR_SR_LAST)
        |=> status_byte_five == $past(b2_reg))
        else $error("indirect write to last register lost");

    lock_cause_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_lock_rise |-> $past(latch) && $past(prot_high) && $past(prot_low)
                        && $past(cmd_reg) == CMD_LOCK)
        else $error("lock set without enable and protect bits");

    lock_keys_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_lock_rise |-> $past(b1_reg) == LOCK_KEY1 && $past(b2_reg) == LOCK_KEY2)
        else $error("lock set without both keys in order");

    vol_once_a: assert property (@(posedge clk) disable iff (!rst_n)
        frame_end && aligned && (cmd_reg == CMD_DIRECT || cmd_reg == CMD_INDIRECT)
        |=> !volatile_enable)
        else $error("volatile enable survived a status write");

    deselect_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
        cs_n_s [*2] |-> bit_cnt == BIT_ZERO && byte_cnt == CNT_NONE)
        else $error("frame counters not cleared while deselected");

    // Each direct opcode lands in its own register
    sr1_direct_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_direct_end ##0 (wr_allow && op_reg == OP_WR_SR1 && body_cnt == BODY_ONE)
        |=> sr1_kept == ($past(b1_reg) & ~latch_mask))
        else $error("single byte write to register one lost");

    sr2_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_direct_end ##0 (wr_allow && op_reg == OP_WR_SR2 && body_cnt == BODY_ONE)
        |=> status_byte_two == $past(b1_reg))
        else $error("direct write to register two lost");

    sr3_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_direct_end ##0 (wr_allow && op_reg == OP_WR_SR3 && body_cnt == BODY_ONE)
        |=> status_byte_three == $past(b1_reg))
        else $error("direct write to register three lost");

    // Enables and the latch
    vol_keeps_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_vwren_frame |=> volatile_enable && $stable(write_enable_latch))
        else $error("volatile enable frame disturbed the latch");

    ind_no_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_ind_end ##0 !latch |=> s_data_held)
        else $error("indirect write ran without the latch");

    ind_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_ind_end |=> !write_enable_latch)
        else $error("write enable still set after indirect write");

    lock_blocks_a: assert property (@(posedge clk) disable iff (!rst_n)
        frame_end && lock_reg |=> s_data_held)
        else $error("status byte written while locked");

    other_ignored_a: assert property (@(posedge clk) disable iff (!rst_n)
        frame_end && aligned && cmd_reg == CMD_OTHER |=> $stable(sr_reg) && $stable(vol_reg))
        else $error("unknown opcode changed state");

    // Byte positions within the frame
    op_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        byte_valid && byte_cnt == CNT_OPCODE |=> op_reg == $past(byte_data))
        else $error("opcode byte not captured");

    addr_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        byte_valid && byte_cnt == CNT_FIRST |=> b1_reg == $past(byte_data))
        else $error("first body byte not captured");

    data_capture_a: assert property (@(posedge clk) disable iff (!rst_n)
        byte_valid && byte_cnt == CNT_SECOND |=> b2_reg == $past(byte_data))
        else $error("second body byte not captured");

endmodule

// ==== rtl/swp_pkg.sv ====
package swp_pkg;

    // Widths and counts of the serial frame
    localparam int REG_W      = 8;
    localparam int NUM_SR     = 5;
    localparam int BIT_CNT_W  = 3;
    localparam int BYTE_CNT_W = 3;
    localparam int SYNC_W     = 3;

    localparam logic [BIT_CNT_W-1:0]  BIT_LAST     = 3'h7;
    localparam logic [BIT_CNT_W-1:0]  BIT_ZERO     = 3'h0;
    localparam logic [BYTE_CNT_W-1:0] BYTE_CNT_MAX = 3'h4;
    localparam logic [BYTE_CNT_W-1:0] CNT_NONE     = 3'h0;
    localparam logic [BYTE_CNT_W-1:0] CNT_OPCODE   = 3'h1;
    localparam logic [BYTE_CNT_W-1:0] CNT_FIRST    = 3'h2;
    localparam logic [BYTE_CNT_W-1:0] CNT_SECOND   = 3'h3;
    localparam logic [BYTE_CNT_W-1:0] BODY_ONE     = 3'h1;
    localparam logic [BYTE_CNT_W-1:0] BODY_TWO     = 3'h2;

    // Command opcodes and lock keys
    localparam logic [REG_W-1:0] OP_WR_SR1 = 8'h01;
    localparam logic [REG_W-1:0] OP_WR_SR2 = 8'h31;
    localparam logic [REG_W-1:0] OP_WR_SR3 = 8'h11;
    localparam logic [REG_W-1:0] OP_WR_IND = 8'h71;
    localparam logic [REG_W-1:0] OP_WREN   = 8'h06;
    localparam logic [REG_W-1:0] OP_VWREN  = 8'h50;
    localparam logic [REG_W-1:0] OP_LOCK   = 8'h6F;
    localparam logic [REG_W-1:0] LOCK_KEY1 = 8'h4D;
    localparam logic [REG_W-1:0] LOCK_KEY2 = 8'h67;

    // Indirect offsets of the five status bytes
    localparam logic [REG_W-1:0] ADDR_SR_FIRST = 8'h01;
    localparam logic [REG_W-1:0] ADDR_SR_LAST  = 8'h05;

    // Array indices and field positions
    localparam int IDX_SR1       = 0;
    localparam int IDX_SR2       = 1;
    localparam int IDX_SR3       = 2;
    localparam int LATCH_BIT     = 1;
    localparam int PROT_LOW_BIT  = 7;
    localparam int PROT_HIGH_BIT = 0;

    localparam logic [REG_W-1:0]  SR_RESET  = 8'h00;
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 3'h4;

    typedef enum logic [2:0] {
        CMD_NONE, CMD_DIRECT, CMD_INDIRECT, CMD_LOCK, CMD_WREN, CMD_VWREN, CMD_OTHER
    } swp_cmd_t;

    // Opcode class, used by the capture logic
    function automatic swp_cmd_t cmd_of(input logic [REG_W-1:0] op);
        case (op)
            OP_WR_SR1, OP_WR_SR2, OP_WR_SR3: cmd_of = CMD_DIRECT;
            OP_WR_IND: cmd_of = CMD_INDIRECT;
            OP_LOCK:   cmd_of = CMD_LOCK;
            OP_WREN:   cmd_of = CMD_WREN;
            OP_VWREN:  cmd_of = CMD_VWREN;
            default:   cmd_of = CMD_OTHER;
        endcase
    endfunction

    // Offset within the implemented status bytes
    function automatic logic addr_ok(input logic [REG_W-1:0] addr);
        addr_ok = (addr >= ADDR_SR_FIRST) && (addr <= ADDR_SR_LAST);
    endfunction

endpackage

// ==== rtl/swp_sync.sv ====
module swp_sync #(
    parameter int                        WIDTH   = swp_pkg::SYNC_W,
    parameter logic [WIDTH-1:0]          RST_VAL = swp_pkg::SYNC_IDLE
) (
    input  logic             clk,
    input  logic             rst_n,
    input  logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import swp_pkg::*;

    logic [WIDTH-1:0] meta_reg;

    // Two stages; the first is read only by the second
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ==== rtl/swp_byte_rx.sv ====
module swp_byte_rx (
    input  logic                            clk,
    input  logic                            rst_n,
    input  logic                            cs_n_s,
    input  logic                            sclk_s,
    input  logic                            si_s,
    output logic                            byte_valid,
    output logic [swp_pkg::REG_W-1:0]       byte_data,
    output logic [swp_pkg::BIT_CNT_W-1:0]   bit_cnt,
    output logic [swp_pkg::BYTE_CNT_W-1:0]  byte_cnt
);
    import swp_pkg::*;

    logic             sclk_d_reg;
    logic [REG_W-1:0] shift_reg;

    // Rising serial clock edge, modes 0 and 3 alike
    wire              sclk_rise  = sclk_s & ~sclk_d_reg;
    wire              byte_end   = sclk_rise & (bit_cnt == BIT_LAST);
    wire [REG_W-1:0]  shift_next = {shift_reg[REG_W-2:0], si_s};
    wire [BYTE_CNT_W-1:0] cnt_inc =
        (byte_cnt == BYTE_CNT_MAX) ? byte_cnt : byte_cnt + BYTE_CNT_W'(1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
        end
    end

    // Counters restart while chip select is high
    always_ff @(posedge clk) begin
        if (!rst_n || cs_n_s) begin
            shift_reg  <= SR_RESET;
            bit_cnt    <= BIT_ZERO;
            byte_cnt   <= CNT_NONE;
            byte_valid <= 1'b0;
            byte_data  <= SR_RESET;
        end else begin
            byte_valid <= byte_end;
            if (sclk_rise) begin
                shift_reg <= shift_next;         // MSB first
                bit_cnt   <= bit_cnt + BIT_CNT_W'(1);
            end
            if (byte_end) begin
                byte_data <= shift_next;
                byte_cnt  <= cnt_inc;            // Saturates, longer frames stay invalid
            end
        end
    end

endmodule

// ==== dv/swp_host.sv ====
module swp_host (
    input  logic clk,
    output logic cs_n,
    output logic sclk,
    output logic si
);
    timeunit 1ns;
    timeprecision 1ps;

    // Deselected and idle at time zero; the serial clock stands low between frames
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end

    // One frame, left-aligned in v, mode 0: data set while sclk is low, taken on its rise.
    // A count off a byte boundary is sent only where the bench wants the abort.
    task automatic send(input logic [31:0] v, input int nbits);
        logic [31:0] sh;
        sh = v;
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (10) @(posedge clk);
        for (int i = 0; i < nbits; i++) begin
            si <= sh[31];                        // MSB first
            sh = sh << 1;
            repeat (10) @(posedge clk);
            sclk <= 1'b1;
            repeat (10) @(posedge clk);
            sclk <= 1'b0;
        end
        // Settle time before release; the whole command is in by now
        repeat (10) @(posedge clk);
        cs_n <= 1'b1;
        si   <= ~si;                             // Released line shows no stale value
        // Gap long enough for the outputs to settle after the frame end
        repeat (12) @(posedge clk);
    endtask
endmodule

// ==== dv/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import swp_pkg::*;

    logic             clk   = 1'b0;
    logic             rst_n = 1'b0;
    logic             cs_n;
    logic             sclk;
    logic             si;
    logic [REG_W-1:0] sr [1:5];
    logic [REG_W-1:0] ex [1:5];
    logic             write_enable_latch;
    logic             protect_lock_bit_high;
    logic             protect_lock_bit_low;
    logic             volatile_enable;
    logic             regs_locked;
    int               errors  = 0;
    int               checked = 0;

    // 250 MHz system clock
    always #2 clk = ~clk;

    swp_host host (.clk(clk), .cs_n(cs_n), .sclk(sclk), .si(si));

    swp_status_write DUT (
        .clk                   (clk),
        .rst_n                 (rst_n),
        .cs_n                  (cs_n),
        .sclk                  (sclk),
        .si                    (si),
        .status_byte_one       (sr[1]),
        .status_byte_two       (sr[2]),
        .status_byte_three     (sr[3]),
        .status_byte_four      (sr[4]),
        .status_byte_five      (sr[5]),
        .write_enable_latch    (write_enable_latch),
        .protect_lock_bit_high (protect_lock_bit_high),
        .protect_lock_bit_low  (protect_lock_bit_low),
        .volatile_enable       (volatile_enable),
        .regs_locked           (regs_locked)
    );

    task automatic close_out();
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Status bytes, latch and protect bits against the model; the latch bit is never taken from data
    task automatic chk_all(input logic en);
        chk(sr[1], ex[1] | {6'h00, en, 1'b0});
        for (int i = 2; i <= 5; i++) begin
            chk(sr[i], ex[i]);
        end
        chk({7'h00, write_enable_latch}, {7'h00, en});
        chk({7'h00, protect_lock_bit_low}, {7'h00, ex[1][7]});
        chk({7'h00, protect_lock_bit_high}, {7'h00, ex[2][0]});
    endtask

    task automatic wren();
        host.send({OP_WREN, 24'h0}, 8);
    endtask

    task automatic t_reset();
        chk_all(1'b0);
        chk({7'h00, volatile_enable}, 8'h00);
        chk({7'h00, regs_locked}, 8'h00);
    endtask

    task automatic t_direct();
        wren();
        chk_all(1'b1);
        host.send({OP_WR_SR1, 8'hA6, 8'h3C, 8'h00}, 24);
        ex[1] = 8'hA4;
        ex[2] = 8'h3C;
        chk_all(1'b0);
        host.send({OP_WR_SR2, 8'h77, 16'h0}, 16);
        chk_all(1'b0);
        wren();
        host.send({OP_WR_SR1, 8'h21, 16'h0}, 16);
        ex[1] = 8'h21;
        chk_all(1'b0);
    endtask

    // Volatile enable leaves the latch alone and covers one write only
    task automatic t_volatile();
        host.send({OP_VWREN, 24'h0}, 8);
        chk({7'h00, volatile_enable}, 8'h01);
        chk_all(1'b0);
        host.send({OP_WR_SR3, 8'h5A, 16'h0}, 16);
        ex[3] = 8'h5A;
        chk_all(1'b0);
        chk({7'h00, volatile_enable}, 8'h00);
        host.send({OP_WR_SR3, 8'hC3, 16'h0}, 16);
        chk_all(1'b0);
    endtask

    task automatic t_unaligned();
        wren();
        host.send({8'hA5, 8'h12, 16'h0}, 16);
        chk_all(1'b1);
        host.send({OP_WR_SR2, 8'h99, 16'h0}, 12);
        chk_all(1'b1);
        host.send({OP_WR_SR2, 8'h98, 16'h0}, 16);
        ex[2] = 8'h98;
        chk_all(1'b0);
    endtask

    task automatic t_indirect();
        logic [7:0] bad [3];
        bad = '{8'h00, 8'h06, 8'hFF};
        for (logic [7:0] ad = 8'h01; ad <= 8'h05; ad++) begin
            wren();
            host.send({OP_WR_IND, ad, 8'h40 + ad, 8'h00}, 24);
            ex[ad] = 8'h40 + ad;
            chk_all(1'b0);
        end
        for (int i = 0; i < 3; i++) begin
            wren();
            host.send({OP_WR_IND, bad[i], 8'h55, 8'h00}, 24);
            chk_all(1'b0);
        end
        host.send({OP_WR_IND, 8'h03, 8'h55, 8'h00}, 24);
        chk_all(1'b0);
        wren();
        host.send({OP_WR_IND, 8'h03, 8'h55, 8'h66}, 32);
        chk_all(1'b0);
    endtask

    task automatic t_lock();
        wren();
        host.send({OP_LOCK, LOCK_KEY1, LOCK_KEY2, 8'h00}, 24);
        chk({7'h00, regs_locked}, 8'h00);
        wren();
        host.send({OP_WR_SR1, 8'h80, 8'h01, 8'h00}, 24);
        ex[1] = 8'h80;
        ex[2] = 8'h01;
        chk_all(1'b0);
        wren();
        host.send({OP_LOCK, LOCK_KEY2, LOCK_KEY1, 8'h00}, 24);
        chk({7'h00, regs_locked}, 8'h00);
        chk_all(1'b0);
        host.send({OP_LOCK, LOCK_KEY1, LOCK_KEY2, 8'h00}, 24);
        chk({7'h00, regs_locked}, 8'h00);
        wren();
        host.send({OP_LOCK, LOCK_KEY1, LOCK_KEY2, 8'h00}, 24);
        chk({7'h00, regs_locked}, 8'h01);
        wren();
        host.send({OP_WR_IND, 8'h03, 8'hAA, 8'h00}, 24);
        chk_all(1'b0);
        host.send({OP_VWREN, 24'h0}, 8);
        host.send({OP_WR_SR3, 8'h3E, 16'h0}, 16);
        chk_all(1'b0);
        chk({7'h00, volatile_enable}, 8'h00);
    endtask

    // Reset in mid-run clears the sticky lock and every status byte
    task automatic t_rearm();
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 1; i <= 5; i++) begin
            ex[i] = SR_RESET;
        end
        t_reset();
        wren();
        host.send({OP_WR_SR3, 8'h3E, 16'h0}, 16);
        ex[3] = 8'h3E;
        chk_all(1'b0);
    endtask

    // Watchdog: a run this long means something hung
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        close_out();
    end

    // Reset held six cycles with the host deselected, then the scenarios in turn
    initial begin
        for (int i = 1; i <= 5; i++) begin
            ex[i] = SR_RESET;
        end
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_direct();
        t_volatile();
        t_unaligned();
        t_indirect();
        t_lock();
        t_rearm();
        close_out();
    end
endmodule
